// *** core/frc_pkg.sv ***
/*
 * Package for the fixed reference control block: register map, field layout,
 * reset values, gain encodings and the carrier structs shared by its files.
 * Assumes a 32-bit APB slave port and one system clock.
 */
package frc_pkg;

    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] REF_CTRL_OFFSET = 12'h000;
    localparam int unsigned READY_BIT       = 7;
    localparam int unsigned ENABLE_BIT      = 6;
    localparam int unsigned GAIN_LSB        = 0;
    localparam int unsigned GAIN_W          = 2;
    localparam logic        ENABLE_RESET    = 1'b0;
    localparam logic [1:0]  GAIN_RESET      = 2'h0;
    localparam int unsigned SETTLE_CYCLES   = 16;
    localparam int unsigned SETTLE_W        = 16;
    localparam logic [15:0] SETTLE_ZERO     = 16'h0000;
    localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;

    typedef enum logic [1:0] {
        FRC_GAIN_OFF,
        FRC_GAIN_X1,
        FRC_GAIN_X2,
        FRC_GAIN_X4
    } frc_gain_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } frc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } frc_apb_rsp_s;

    typedef struct packed {
        logic      buffer_on;
        frc_gain_e gain;
        logic      channel_valid;
    } frc_conv_s;

endpackage

// *** core/frc_settle.sv ***
/*
 * Settling timer: models the reference start-up delay as a cycle count.
 * Assumes enable comes from a register on the same clock.
 */
`timescale 1ns/100ps
module frc_settle #(
    parameter int unsigned   LOW_VOLTAGE = 1,
    parameter logic [15:0]   SETTLE      = 16'h0010
) (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    input  wire logic        enable_in,
    output logic             ready_out
);
    import frc_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic        ready;
    } frc_settle_s;

    frc_settle_s state;
    frc_settle_s next_state;

    always_comb begin
        next_state = state;
        if (LOW_VOLTAGE == 0) begin
            next_state.ready = 1'b1;
        end else if (!enable_in) begin
            next_state.count = SETTLE_ZERO;
            next_state.ready = 1'b0;
        end else if (state.count == SETTLE) begin
            next_state.ready = 1'b1;
        end else begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state.count <= SETTLE_ZERO;
            state.ready <= (LOW_VOLTAGE == 0);
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    assign ready_out = state.ready;

endmodule

// *** core/frc_top.sv ***
/*
 * Fixed reference control register behind an APB slave.
 * Assumes an APB master on clock_in; the analog reference is a status model.
 */
`timescale 1ns/100ps
module frc_top #(
    parameter int unsigned LOW_VOLTAGE = 1,
    parameter logic [15:0] SETTLE      = 16'h0010
) (
    input  wire logic                  clock_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  clk_en_in,
    input  wire frc_pkg::frc_apb_req_s apb_req_in,
    output frc_pkg::frc_apb_rsp_s      apb_rsp_out,
    output frc_pkg::frc_conv_s         conv_out
);
    import frc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic         enable;
        frc_gain_e    gain;
        frc_apb_rsp_s rsp;
        frc_conv_s    conv;
    } frc_top_s;

    frc_top_s state;
    frc_top_s next_state;
    logic     ready;
    logic     hit;
    logic     access;

    frc_settle #(
        .LOW_VOLTAGE (LOW_VOLTAGE),
        .SETTLE      (SETTLE)
    ) u_settle (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .enable_in  (state.enable),
        .ready_out  (ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // The access phase answers after one wait state, since pready is registered.
    assign access = apb_req_in.psel && apb_req_in.penable && !state.rsp.pready;
    assign hit    = (apb_req_in.paddr == REF_CTRL_OFFSET);

    always_comb begin
        next_state              = state;
        next_state.rsp.pready   = access;
        next_state.rsp.pslverr  = access && !hit;
        next_state.rsp.prdata   = DATA_ZERO;
        if (access && hit && apb_req_in.pwrite) begin
            next_state.enable = apb_req_in.pwdata[ENABLE_BIT];
            next_state.gain = frc_gain_e'(apb_req_in.pwdata[GAIN_LSB +: GAIN_W]);
        end
        if (access && hit && !apb_req_in.pwrite) begin
            next_state.rsp.prdata[READY_BIT]          = ready;
            next_state.rsp.prdata[ENABLE_BIT]         = state.enable;
            next_state.rsp.prdata[GAIN_LSB +: GAIN_W] = state.gain;
        end
        next_state.conv.buffer_on     = state.enable;
        next_state.conv.gain          = state.enable ? state.gain : FRC_GAIN_OFF;
        next_state.conv.channel_valid = ready && state.enable
                                        && (state.gain != FRC_GAIN_OFF);
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state.enable <= ENABLE_RESET;
            state.gain   <= frc_gain_e'(GAIN_RESET);
            state.rsp    <= '0;
            state.conv   <= '0;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    assign apb_rsp_out = state.rsp;
    assign conv_out    = state.conv;

    ////////////////////////////////////////////////////////////////////////
    property p_write_enable;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && access && hit && apb_req_in.pwrite)
            |=> (state.enable == $past(apb_req_in.pwdata[ENABLE_BIT]));
    endproperty
    a_write_enable: assert property (p_write_enable) else $error("enable not written");

    property p_write_gain;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && access && hit && apb_req_in.pwrite)
            |=> (state.gain == $past(apb_req_in.pwdata[1:0]));
    endproperty
    a_write_gain: assert property (p_write_gain) else $error("gain not written");

    property p_read_unused;
        @(posedge clock_in) disable iff (sys_rst_in)
        apb_rsp_out.pready |-> (apb_rsp_out.prdata[5:2] == 4'h0);
    endproperty
    a_read_unused: assert property (p_read_unused) else $error("unused bits nonzero");

    property p_read_ready;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && access && hit && !apb_req_in.pwrite)
            |=> (apb_rsp_out.prdata[7] == $past(ready));
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("ready readback wrong");

    property p_std_ready;
        @(posedge clock_in) disable iff (sys_rst_in)
        (LOW_VOLTAGE == 0) |-> ready;
    endproperty
    a_std_ready: assert property (p_std_ready) else $error("standard part not ready");

    property p_off_not_ready;
        @(posedge clock_in) disable iff (sys_rst_in)
        (LOW_VOLTAGE != 0 && clk_en_in && !state.enable) |=> !ready;
    endproperty
    a_off_not_ready: assert property (p_off_not_ready) else $error("ready while off");

    sequence s_enabled_hold;
        (state.enable && clk_en_in)[*8];
    endsequence

    property p_settle_delay;
        @(posedge clock_in) disable iff (sys_rst_in)
        (LOW_VOLTAGE != 0 && SETTLE > 16'h0008 && !state.enable) ##1 s_enabled_hold
            |-> !ready;
    endproperty
    a_settle_delay: assert property (p_settle_delay) else $error("ready too early");

    property p_channel;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && !state.enable) |=> (conv_out.gain == FRC_GAIN_OFF);
    endproperty
    a_channel: assert property (p_channel) else $error("channel on while off");

    sequence s_read_taken;
        clk_en_in && access && hit && !apb_req_in.pwrite;
    endsequence

    property p_read_enable;
        @(posedge clock_in) disable iff (sys_rst_in)
        s_read_taken |=> (apb_rsp_out.prdata[ENABLE_BIT] == $past(state.enable));
    endproperty
    a_read_enable: assert property (p_read_enable) else $error("enable readback");

    property p_read_gain;
        @(posedge clock_in) disable iff (sys_rst_in)
        s_read_taken |=> (apb_rsp_out.prdata[1:0] == $past(state.gain));
    endproperty
    a_read_gain: assert property (p_read_gain) else $error("gain readback");

    property p_read_upper;
        @(posedge clock_in) disable iff (sys_rst_in)
        apb_rsp_out.pready |-> (apb_rsp_out.prdata[31:8] == 24'h00_0000);
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper bits nonzero");

    // An unmapped access must leave the register alone and flag an error.
    property p_unmapped;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && access && !hit)
            |=> (apb_rsp_out.pslverr && $stable(state.enable) && $stable(state.gain));
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");

    property p_pready_pulse;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && apb_rsp_out.pready) |=> !apb_rsp_out.pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");

    property p_ready_stays;
        @(posedge clock_in) disable iff (sys_rst_in)
        (LOW_VOLTAGE != 0 && clk_en_in && ready && state.enable) |=> ready;
    endproperty
    a_ready_stays: assert property (p_ready_stays) else $error("ready dropped");

    // A low clock enable must hold every register, bus answer included.
    property p_freeze;
        @(posedge clock_in) disable iff (sys_rst_in)
        !clk_en_in |=> $stable(state);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_buffer_on;
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in |=> (conv_out.buffer_on == $past(state.enable));
    endproperty
    a_buffer_on: assert property (p_buffer_on) else $error("buffer enable wrong");

    property p_channel_gain;
        @(posedge clock_in) disable iff (sys_rst_in)
        (clk_en_in && state.enable) |=> (conv_out.gain == $past(state.gain));
    endproperty
    a_channel_gain: assert property (p_channel_gain) else $error("channel gain wrong");

    property p_channel_valid;
        @(posedge clock_in) disable iff (sys_rst_in)
        conv_out.channel_valid |-> (conv_out.buffer_on && conv_out.gain != FRC_GAIN_OFF);
    endproperty
    a_channel_valid: assert property (p_channel_valid) else $error("channel valid wrong");

endmodule

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the fixed reference control register over APB.
 * Assumes frc_pkg and the core files are compiled first; one clock domain.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module tb_top;
    import frc_pkg::*;
    // A settle count above eight keeps the early-ready check live; waits derive from it.
    localparam logic [15:0] SETTLE_TB = 16'h000A;
    logic         clock_in;
    logic         sys_rst_in;
    logic         clk_en_in;
    frc_apb_req_s req;
    frc_apb_rsp_s rsp;
    frc_apb_rsp_s rsp_std;
    frc_conv_s    conv;
    int           n_fail;
    int           tests_run;
    int           cycles;
    int           seed;
    logic [31:0]  rd;
    logic [31:0]  rd_std;
    logic         err;
    logic [31:0]  wd;
    logic         en;
    logic [1:0]   gn;
    frc_top #(.LOW_VOLTAGE(1), .SETTLE(SETTLE_TB)) u_dut (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .apb_req_in(req),
        .apb_rsp_out(rsp), .conv_out(conv));
    frc_top #(.LOW_VOLTAGE(0), .SETTLE(SETTLE_TB)) u_std (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .apb_req_in(req),
        .apb_rsp_out(rsp_std), .conv_out());
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_reg(input logic r, input logic e, input logic [1:0] g);
        return {24'h00_0000, r, e, 4'h0, g};
    endfunction
    task automatic summarize;
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Starting on a fresh edge leaves one idle cycle, so no signal is driven twice at once.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clock_in);
        req.penable <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, rsp.pready)
        rd = rsp.prdata;
        rd_std = rsp_std.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic r, input logic e, input logic [1:0] g);
        apb(1'b0, REF_CTRL_OFFSET, 32'h0000_0000);
        `CHK("slverr", 1'b0, err)
        `CHK("reg", exp_reg(r, e, g), rd)
        `CHK("std_reg", exp_reg(1'b1, e, g), rd_std)
    endtask
    task automatic conv_chk(input logic r, input logic e, input logic [1:0] g);
        `CHK("buffer_on", e, conv.buffer_on)
        `CHK("gain", (e ? g : 2'h0), conv.gain)
        `CHK("channel", (r & e & (g != 2'h0)), conv.channel_valid)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize;
        end
    end
    initial begin
        seed = 54;
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        clk_en_in = 1'b1;
        sys_rst_in = 1'b1;
        req = '0;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd_chk(1'b0, 1'b0, 2'h0);
        conv_chk(1'b0, 1'b0, 2'h0);
        // Read straight after enabling: the low-voltage part is still settling.
        apb(1'b1, REF_CTRL_OFFSET, 32'h0000_0041);
        rd_chk(1'b0, 1'b1, 2'h1);
        repeat (3 * SETTLE_TB) @(posedge clock_in);
        rd_chk(1'b1, 1'b1, 2'h1);
        conv_chk(1'b1, 1'b1, 2'h1);
        apb(1'b1, 12'h004, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_rd", 32'h0000_0000, rd)
        rd_chk(1'b1, 1'b1, 2'h1);
        // The first eight sweep every enable and gain code; the rest are random words.
        for (int i = 0; i < 24; i++) begin
            wd = $random(seed);
            if (i < 8) begin
                wd[6] = i[2];
                wd[1:0] = i[1:0];
            end
            en = wd[6];
            gn = wd[1:0];
            apb(1'b1, REF_CTRL_OFFSET, wd);
            repeat (3 * SETTLE_TB) @(posedge clock_in);
            rd_chk(en, en, gn);
            conv_chk(en, en, gn);
        end
        // A low clock enable must freeze the settling count part way.
        apb(1'b1, REF_CTRL_OFFSET, 32'h0000_0000);
        apb(1'b1, REF_CTRL_OFFSET, 32'h0000_0042);
        clk_en_in <= 1'b0;
        repeat (3 * SETTLE_TB) @(posedge clock_in);
        clk_en_in <= 1'b1;
        rd_chk(1'b0, 1'b1, 2'h2);
        repeat (3 * SETTLE_TB) @(posedge clock_in);
        rd_chk(1'b1, 1'b1, 2'h2);
        conv_chk(1'b1, 1'b1, 2'h2);
        // A second reset in mid-run returns every field to its default.
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd_chk(1'b0, 1'b0, 2'h0);
        conv_chk(1'b0, 1'b0, 2'h0);
        summarize;
    end
endmodule
